// ---- core/se_defines.vh ----
`ifndef SE_DEFINES_VH
`define SE_DEFINES_VH
// Op-codes, bit 3 is don't-care
`define SE_OPC_MASK 8'hF7
`define SE_OPC_LATCH_SET 8'h06
`define SE_OPC_LATCH_CLR 8'h04
`define SE_OPC_STAT_RD 8'h05
`define SE_OPC_STAT_WR 8'h01
`define SE_OPC_READ 8'h03
`define SE_OPC_WRITE 8'h02
// Status byte fields
`define SE_ST_BUSY 0
`define SE_ST_WEN 1
`define SE_ST_BP_LO 2
`define SE_ST_BP_HI 3
`define SE_ST_GUARD_EN 7
`define SE_ST_BUSY_VAL 8'hFF
// Reset and power-up values
`define SE_WEN_RST 1'b0
`define SE_BP_INIT 2'h0
`define SE_GUARD_EN_INIT 1'b0
// Geometry
`define SE_ADDR_BYTES 2
`define SE_PAGE_BYTES 32
`define SE_DEPTH 2048
`define SE_AW 11
`define SE_FIFO_DEPTH 16
`define SE_FIFO_AW 4
// Timing
`define SE_CLK_MHZ 50
`define SE_TWR_MS 5
`define SE_TWR_CYC 18'h3D090
`define SE_TWR_W 18
`endif

// ---- core/se_spi_eeprom.v ----
// Notes on behaviour
// - Serial clock is only ever an input; device is always the slave.
// - Data arrives on the serial input pin, leaves on a separate output pin.
// - Op-codes, addresses and data move most significant bit first.
// - First eight bits after select falls form the op-code.
// - Unknown op-code: ignore the rest, output stays off until select falls again.
// - Deselected: serial input ignored, output high impedance.
// - Pause released while clock low; clock edges during pause change nothing.
// - Pause raised while clock high takes effect when clock next falls.
// - While paused, serial input activity is disregarded.
// - Write guard high allows writes; low blocks every write.
// - Guard falling while selected aborts the pending write.
// - Guard changes never disturb a running internal write cycle.
// - Inputs sampled on rising clock, outputs change on falling clock.
// - After power-up nothing starts until select shows a falling edge.
// - While power-on reset is active, all instructions are ignored.
// - Select low means active; standby only once write cycle is over.
// - Programming is a self-timed cycle of at most 5 ms, no erase.
// - One page write takes up to 32 bytes within one page.
// - Array holds bytes, depth 128 to 2048 by parameter.
// - Protection level: none, upper quarter, upper half, or whole array.
// - Eight-bit op-codes with bit 3 ignored, six instructions decoded.
// - Status bit 0 busy, bit 1 write latch; all ones while busy.
// - Programming needs the write latch set beforehand.
// - Reset clears the write latch; protection bits keep their values.
`timescale 1ns/1ps
`default_nettype none
`include "se_defines.vh"

module se_fifo #(
    parameter W = 8,
    parameter D = `SE_FIFO_DEPTH,
    parameter AW = `SE_FIFO_AW
) (
    input wire clk_i, // Clock
    input wire rst_n_i, // Async reset, active low
    input wire flush_i, // Empty the buffer
    input wire in_valid_i, // Write side valid
    output wire in_ready_o, // Write side ready
    input wire [W-1:0] in_data_i, // Write data
    output wire out_valid_o, // Read side valid
    input wire out_ready_i, // Read side ready
    output wire [W-1:0] out_data_o // Read data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_reg != D[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_i;
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end
        else if (flush_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule // se_fifo

module se_spi_eeprom #(
    parameter DEPTH = `SE_DEPTH,
    parameter AW = `SE_AW,
    parameter [`SE_TWR_W-1:0] TWR_CYC = `SE_TWR_CYC
) (
    input wire mclk_i, // 50 MHz system clock
    input wire rst_n_i, // Power-on reset, active low
    input wire sck_i, // Serial clock from master
    input wire cs_n_i, // Select, active low
    input wire si_i, // Serial data in
    input wire hold_n_i, // Pause, active low
    input wire wp_n_i, // Write guard, active low
    output wire so_o, // Serial data out
    output wire so_oe_n_o, // Output enable, low while driving
    output wire active_o, // Active mode
    output wire standby_o, // Standby mode
    output wire busy_o // Internal write cycle running
);
    localparam ST_IDLE = 3'h0;
    localparam ST_OPC = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_RDATA = 3'h3;
    localparam ST_WDATA = 3'h4;
    localparam ST_STRD = 3'h5;
    localparam ST_STWR = 3'h6;
    localparam ST_IGN = 3'h7;

    function opc_is;
        input [7:0] b;
        input [7:0] code;
        begin
            opc_is = ((b & `SE_OPC_MASK) == code);
        end
    endfunction

    function is_prot;
        input [AW-1:0] a;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h0: is_prot = 1'b0;
                2'h1: is_prot = ({1'b0, a} >= ((DEPTH / 4) * 3));
                2'h2: is_prot = ({1'b0, a} >= (DEPTH / 2));
                default: is_prot = 1'b1;
            endcase
        end
    endfunction

    reg [7:0] mem [0:DEPTH-1];
    reg [7:0] pbuf [0:`SE_PAGE_BYTES-1];

    // Pin synchronisers: sck, cs_n, si, hold_n, wp_n
    reg [4:0] s1_reg;
    reg [4:0] s2_reg;
    reg sck_prev_reg;
    reg cs_prev_reg;
    reg wp_prev_reg;
    wire sck_s = s2_reg[0];
    wire cs_s = s2_reg[1];
    wire si_s = s2_reg[2];
    wire hold_s = s2_reg[3];
    wire wp_s = s2_reg[4];

    reg sel_reg;
    reg held_reg;
    reg [2:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [6:0] rx_sr_reg;
    reg [15:0] addr_reg;
    reg [1:0] addr_cnt_reg;
    reg is_read_reg;
    reg wen_reg;
    reg abort_reg;
    reg load_pend_reg;
    reg tx_on_reg;
    reg so_reg;
    reg [6:0] tx_sr_reg;
    reg [4:0] wptr_reg;
    reg [AW-1:0] page_base_reg;
    reg [`SE_PAGE_BYTES-1:0] pmask_reg;
    reg [7:0] sr_new_reg;
    reg sr_pend_reg;
    reg [1:0] bp_reg = `SE_BP_INIT;
    reg guard_pin_enable_reg = `SE_GUARD_EN_INIT;
    reg busy_reg;
    reg [`SE_TWR_W-1:0] twr_cnt_reg;
    reg [5:0] cmt_idx_reg;
    reg cmt_arr_reg;
    reg cmt_sr_reg;
    // Own copy of the byte mask, the frame side clears its mask at deselect
    reg [`SE_PAGE_BYTES-1:0] cmt_mask_reg;
    reg [AW-1:0] pf_addr_reg;
    reg pf_on_reg;

    wire sck_rise = sck_s & ~sck_prev_reg & ~held_reg;
    wire sck_fall = ~sck_s & sck_prev_reg & ~held_reg;
    wire cs_fall = ~cs_s & cs_prev_reg;
    wire [7:0] rx_byte = {rx_sr_reg, si_s};
    wire byte_done = sel_reg & sck_rise & (bit_cnt_reg == 3'h7);
    wire [15:0] addr_full = {addr_reg[7:0], rx_byte};
    wire last_addr = (addr_cnt_reg == (`SE_ADDR_BYTES - 1));
    wire start_pf = byte_done & (state_reg == ST_ADDR) & last_addr & is_read_reg;
    wire [7:0] status = busy_reg ? `SE_ST_BUSY_VAL :
        {guard_pin_enable_reg, 3'h0, bp_reg, wen_reg, 1'b0};
    wire do_commit = sel_reg & cs_s & ((|pmask_reg) | sr_pend_reg) & wen_reg
        & wp_s & ~abort_reg & ~busy_reg;
    wire wcyc_end = busy_reg & (twr_cnt_reg == TWR_CYC - 1'b1);
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire f_flush = start_pf | (sel_reg & cs_s);
    wire f_pop = sel_reg & sck_fall & load_pend_reg & (state_reg == ST_RDATA);
    wire [7:0] tx_byte = (state_reg == ST_RDATA) ?
        (f_out_valid ? f_out_data : 8'hFF) : status;

    assign so_o = so_reg;
    assign so_oe_n_o = ~(sel_reg & tx_on_reg & ~held_reg);
    assign active_o = sel_reg;
    assign standby_o = ~sel_reg & ~busy_reg;
    assign busy_o = busy_reg;

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
            wp_prev_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= {wp_n_i, hold_n_i, si_i, cs_n_i, sck_i};
            s2_reg <= s1_reg;
            sck_prev_reg <= sck_s;
            cs_prev_reg <= cs_s;
            wp_prev_reg <= wp_s;
        end
    end

    // Pause level is taken over only while the clock is low
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            held_reg <= 1'b0;
        else if (!sel_reg)
            held_reg <= 1'b0;
        else if (!sck_s)
            held_reg <= ~hold_s;
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_reg <= 1'b0;
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            rx_sr_reg <= 7'h00;
            addr_reg <= 16'h0000;
            addr_cnt_reg <= 2'h0;
            is_read_reg <= 1'b0;
            wen_reg <= `SE_WEN_RST;
            abort_reg <= 1'b0;
            load_pend_reg <= 1'b0;
            tx_on_reg <= 1'b0;
            so_reg <= 1'b0;
            tx_sr_reg <= 7'h00;
            wptr_reg <= 5'h00;
            page_base_reg <= {AW{1'b0}};
            pmask_reg <= {`SE_PAGE_BYTES{1'b0}};
            sr_new_reg <= 8'h00;
            sr_pend_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            sel_reg <= 1'b1;
            state_reg <= ST_OPC;
            bit_cnt_reg <= 3'h0;
            addr_cnt_reg <= 2'h0;
            abort_reg <= 1'b0;
            load_pend_reg <= 1'b0;
            tx_on_reg <= 1'b0;
            pmask_reg <= {`SE_PAGE_BYTES{1'b0}};
            sr_pend_reg <= 1'b0;
            if (wcyc_end)
                wen_reg <= 1'b0;
        end
        else if (cs_s || !sel_reg)
        begin
            sel_reg <= 1'b0;
            state_reg <= ST_IDLE;
            tx_on_reg <= 1'b0;
            load_pend_reg <= 1'b0;
            pmask_reg <= {`SE_PAGE_BYTES{1'b0}};
            sr_pend_reg <= 1'b0;
            if (wcyc_end)
                wen_reg <= 1'b0;
        end
        else
        begin
            if (!wp_s && wp_prev_reg)
                abort_reg <= 1'b1;
            if (sck_rise && state_reg != ST_IGN)
            begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                rx_sr_reg <= rx_byte[6:0];
            end
            if (byte_done)
            begin
                case (state_reg)
                    ST_OPC:
                    begin
                        state_reg <= ST_IGN;
                        if (opc_is(rx_byte, `SE_OPC_STAT_RD))
                        begin
                            state_reg <= ST_STRD;
                            load_pend_reg <= 1'b1;
                        end
                        else if (busy_reg)
                            state_reg <= ST_IGN;
                        else if (opc_is(rx_byte, `SE_OPC_LATCH_SET))
                            wen_reg <= 1'b1;
                        else if (opc_is(rx_byte, `SE_OPC_LATCH_CLR))
                            wen_reg <= 1'b0;
                        else if (opc_is(rx_byte, `SE_OPC_STAT_WR))
                            state_reg <= ST_STWR;
                        else if (opc_is(rx_byte, `SE_OPC_READ) ||
                            opc_is(rx_byte, `SE_OPC_WRITE))
                        begin
                            state_reg <= ST_ADDR;
                            is_read_reg <= rx_byte[0];
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_reg <= addr_full;
                        addr_cnt_reg <= addr_cnt_reg + 1'b1;
                        if (last_addr)
                        begin
                            state_reg <= is_read_reg ? ST_RDATA : ST_WDATA;
                            load_pend_reg <= is_read_reg;
                            page_base_reg <= addr_full[AW-1:0];
                            wptr_reg <= addr_full[4:0];
                        end
                    end
                    ST_WDATA:
                    begin
                        pmask_reg[wptr_reg] <= 1'b1;
                        wptr_reg <= wptr_reg + 1'b1;
                    end
                    ST_STWR:
                    begin
                        sr_new_reg <= rx_byte;
                        sr_pend_reg <= 1'b1;
                        state_reg <= ST_IGN;
                    end
                    default:
                        load_pend_reg <= 1'b1;
                endcase
            end
            if (sck_fall && (load_pend_reg || tx_on_reg))
            begin
                tx_on_reg <= 1'b1;
                load_pend_reg <= 1'b0;
                if (load_pend_reg)
                begin
                    so_reg <= tx_byte[7];
                    tx_sr_reg <= tx_byte[6:0];
                end
                else
                begin
                    so_reg <= tx_sr_reg[6];
                    tx_sr_reg <= {tx_sr_reg[5:0], 1'b0};
                end
            end
            if (wcyc_end)
                wen_reg <= 1'b0;
        end
    end

    always @(posedge mclk_i)
    begin
        if (byte_done && state_reg == ST_WDATA)
            pbuf[wptr_reg] <= rx_byte;
    end

    // Self-timed write cycle; the guard pin is no longer looked at here
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_reg <= 1'b0;
            twr_cnt_reg <= {`SE_TWR_W{1'b0}};
            cmt_idx_reg <= 6'h00;
            cmt_arr_reg <= 1'b0;
            cmt_sr_reg <= 1'b0;
            cmt_mask_reg <= {`SE_PAGE_BYTES{1'b0}};
        end
        else if (do_commit)
        begin
            busy_reg <= 1'b1;
            twr_cnt_reg <= {`SE_TWR_W{1'b0}};
            cmt_idx_reg <= 6'h00;
            cmt_arr_reg <= |pmask_reg;
            cmt_sr_reg <= sr_pend_reg;
            cmt_mask_reg <= pmask_reg;
        end
        else if (busy_reg)
        begin
            cmt_sr_reg <= 1'b0;
            if (cmt_idx_reg != `SE_PAGE_BYTES)
                cmt_idx_reg <= cmt_idx_reg + 1'b1;
            if (twr_cnt_reg == TWR_CYC - 1'b1)
            begin
                busy_reg <= 1'b0;
                cmt_arr_reg <= 1'b0;
            end
            else
                twr_cnt_reg <= twr_cnt_reg + 1'b1;
        end
    end

    wire [AW-1:0] cmt_addr = {page_base_reg[AW-1:5], cmt_idx_reg[4:0]};

    always @(posedge mclk_i)
    begin
        if (busy_reg && cmt_arr_reg && cmt_idx_reg != `SE_PAGE_BYTES &&
            cmt_mask_reg[cmt_idx_reg[4:0]] && !is_prot(cmt_addr, bp_reg))
            mem[cmt_addr] <= pbuf[cmt_idx_reg[4:0]];
        if (busy_reg && cmt_sr_reg)
        begin
            bp_reg <= sr_new_reg[`SE_ST_BP_HI:`SE_ST_BP_LO];
            guard_pin_enable_reg <= sr_new_reg[`SE_ST_GUARD_EN];
        end
    end

    // Read prefetch into the FIFO; stalls when it is full
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pf_on_reg <= 1'b0;
            pf_addr_reg <= {AW{1'b0}};
        end
        else if (start_pf)
        begin
            pf_on_reg <= 1'b1;
            pf_addr_reg <= addr_full[AW-1:0];
        end
        else if (f_flush)
            pf_on_reg <= 1'b0;
        else if (pf_on_reg && f_in_ready)
            pf_addr_reg <= (pf_addr_reg == DEPTH - 1) ? {AW{1'b0}} : pf_addr_reg + 1'b1;
    end

    se_fifo #(
        .W(8),
        .D(`SE_FIFO_DEPTH),
        .AW(`SE_FIFO_AW)
    ) se_fifo_i (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .flush_i(f_flush),
        .in_valid_i(pf_on_reg),
        .in_ready_o(f_in_ready),
        .in_data_i(mem[pf_addr_reg]),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_out_data)
    );
endmodule // se_spi_eeprom
`default_nettype wire

// ---- sim/se_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module se_checker #(
    parameter logic [17:0] TWR_CYC = 18'h3D090
) (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic sck_i, // Serial clock
    input wire logic cs_n_i, // Select, active low
    input wire logic si_i, // Serial data in
    input wire logic hold_n_i, // Pause, active low
    input wire logic wp_n_i, // Write guard, active low
    input wire logic so_o, // Serial data out
    input wire logic so_oe_n_o, // Output enable, low while driving
    input wire logic active_o, // Active mode
    input wire logic standby_o, // Standby mode
    input wire logic busy_o // Write cycle running
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    int busy_cnt;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
    end
    sequence sel_start;
        $fell(cs_n_i) ##1 !cs_n_i [*3];
    endsequence
    sequence desel_held;
        cs_n_i [*5];
    endsequence
    sequence out_moved;
        !$stable(so_o) && !so_oe_n_o && !$past(so_oe_n_o);
    endsequence
    sequence paused;
        (!hold_n_i && !sck_i) [*6];
    endsequence
    a_desel_output_off: assert property (desel_held |-> so_oe_n_o && !active_o)
        else $error("output or active seen while deselected");
    a_select_active: assert property (sel_start |-> ##[0:2] active_o)
        else $error("active missing after select");
    a_standby_idle: assert property (standby_o |-> !busy_o && !active_o)
        else $error("standby while busy or selected");
    a_busy_bound: assert property (busy_cnt <= TWR_CYC)
        else $error("write cycle too long");
    a_output_at_fall: assert property (out_moved |-> !sck_i)
        else $error("serial output moved outside clock low phase");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> so_oe_n_o && !active_o && !busy_o)
        else $error("not quiet after reset");
    a_pause_output_off: assert property (paused |-> so_oe_n_o)
        else $error("output driven while paused");
    a_write_start: assert property ($rose(busy_o) |-> cs_n_i && wp_n_i)
        else $error("write cycle started wrongly");
    a_guard_no_abort: assert property (busy_o && $fell(wp_n_i) |=> busy_o)
        else $error("guard fall ended write cycle");
endmodule // se_checker
`default_nettype wire

// ---- sim/se_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module se_master (
    input wire logic mclk_i, // System clock
    input wire logic so_i, // Serial data from device
    input wire logic so_oe_n_i, // Device output enable, low while driving
    output var logic sck_o, // Serial clock
    output var logic cs_n_o, // Select, active low
    output var logic si_o, // Serial data to device
    output var logic hold_n_o // Pause, active low
);
    logic cpol;
    logic last_rx;
    logic drove;
    initial
    begin
        sck_o <= 1'b0;
        cs_n_o <= 1'b0;
        si_o <= 1'b0;
        hold_n_o <= 1'b1;
        cpol = 1'b0;
        last_rx = 1'b0;
        drove = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic start();
        sck_o <= cpol;
        cs_n_o <= 1'b0;
        drove = 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sck_o <= cpol;
        tick(4);
        cs_n_o <= 1'b1;
        tick(8);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck_o <= 1'b0;
            si_o <= tx[i];
            tick(4);
            sck_o <= 1'b1;
            // Released line reads as the inverse of its last level
            rx[i] = so_oe_n_i ? ~last_rx : so_i;
            last_rx = rx[i];
            if (!so_oe_n_i)
                drove = 1'b1;
            tick(4);
        end
    endtask
    task automatic pause(output logic z);
        sck_o <= 1'b0;
        tick(4);
        hold_n_o <= 1'b0;
        tick(8);
        z = so_oe_n_i;
        repeat (3)
        begin
            sck_o <= 1'b1;
            tick(4);
            sck_o <= 1'b0;
            tick(4);
        end
        hold_n_o <= 1'b1;
        tick(4);
    endtask
endmodule // se_master
`default_nettype wire

// ---- sim/test_spi_eeprom_slave_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_slave_front_end;
    localparam logic [17:0] TWR = 18'h000C8;
    logic mclk;
    logic rst_n;
    logic wp_n;
    logic z;
    logic [7:0] rx;
    wire sck, cs_n, si, hold_n, so, so_oe_n, active, standby, busy;
    int fail_count = 0;
    int compares = 0;
    se_spi_eeprom #(.TWR_CYC(TWR)) se_spi_eeprom_i (
        .mclk_i(mclk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n),
        .active_o(active), .standby_o(standby), .busy_o(busy)
    );
    se_master se_master_i (
        .mclk_i(mclk), .so_i(so), .so_oe_n_i(so_oe_n), .sck_o(sck), .cs_n_o(cs_n),
        .si_o(si), .hold_n_o(hold_n)
    );
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        se_master_i.start();
        se_master_i.xfer(op, rx);
        se_master_i.stop();
    endtask
    task automatic status(input logic [7:0] op, input logic [7:0] exp);
        se_master_i.start();
        se_master_i.xfer(op, rx);
        se_master_i.xfer(8'h00, rx);
        se_master_i.stop();
        check("status", rx, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic drop);
        se_master_i.start();
        se_master_i.xfer(8'h02, rx);
        se_master_i.xfer(8'h00, rx);
        se_master_i.xfer(a, rx);
        if (drop)
            wp_n <= 1'b0;
        se_master_i.xfer(8'hA5, rx);
        se_master_i.xfer(8'h3C, rx);
        // Guard back high before deselect, so only the fall in the frame blocks
        if (drop)
            wp_n <= 1'b1;
        se_master_i.stop();
    endtask
    task automatic rd(input logic [7:0] a, input logic hold);
        se_master_i.start();
        se_master_i.xfer(8'h03, rx);
        se_master_i.xfer(8'h00, rx);
        se_master_i.xfer(a, rx);
        if (hold)
        begin
            se_master_i.pause(z);
            check("paused oe_n", z, 1'b1);
        end
        se_master_i.xfer(8'h00, rx);
        check("read 0", rx, 8'hA5);
        se_master_i.xfer(8'h00, rx);
        check("read 1", rx, 8'h3C);
        se_master_i.stop();
    endtask
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        check("busy end", busy, 1'b0);
    endtask
    task automatic t_reset();
        se_master_i.tick(8);
        check("active", active, 1'b0);
        check("standby", standby, 1'b1);
        check("oe_n", so_oe_n, 1'b1);
        se_master_i.stop();
    endtask
    task automatic t_latch();
        for (int x = 0; x < 2; x++)
        begin
            cmd(8'h06 | 8'(x << 3));
            status(8'h05 | 8'(x << 3), 8'h02);
            cmd(8'h04 | 8'(x << 3));
            status(8'h05, 8'h00);
        end
    endtask
    task automatic t_write_read();
        cmd(8'h06);
        wr(8'h10, 1'b0);
        check("busy", busy, 1'b1);
        check("standby", standby, 1'b0);
        wp_n <= 1'b0;
        se_master_i.tick(2);
        check("busy held", busy, 1'b1);
        wp_n <= 1'b1;
        status(8'h05, 8'hFF);
        wait_idle();
        check("standby", standby, 1'b1);
        status(8'h05, 8'h00);
        rd(8'h10, 1'b1);
    endtask
    task automatic t_guard();
        cmd(8'h06);
        wp_n <= 1'b0;
        wr(8'h20, 1'b0);
        check("busy guard", busy, 1'b0);
        wp_n <= 1'b1;
        cmd(8'h06);
        wr(8'h20, 1'b1);
        check("busy abort", busy, 1'b0);
        wp_n <= 1'b1;
        cmd(8'h04);
    endtask
    task automatic t_bad_op();
        se_master_i.xfer(8'h06, rx);
        status(8'h05, 8'h00);
        se_master_i.start();
        se_master_i.xfer(8'hFF, rx);
        se_master_i.xfer(8'h03, rx);
        se_master_i.xfer(8'h00, rx);
        se_master_i.xfer(8'h10, rx);
        se_master_i.xfer(8'h00, rx);
        se_master_i.stop();
        check("bad op drive", se_master_i.drove, 1'b0);
        rd(8'h10, 1'b0);
    endtask
    task automatic t_mode3();
        se_master_i.cpol = 1'b1;
        se_master_i.stop();
        cmd(8'h06);
        status(8'h05, 8'h02);
        se_master_i.start();
        se_master_i.xfer(8'h01, rx);
        se_master_i.xfer(8'h04, rx);
        se_master_i.stop();
        wait_idle();
        status(8'h05, 8'h04);
        cmd(8'h06);
        rst_n <= 1'b0;
        se_master_i.tick(3);
        rst_n <= 1'b1;
        se_master_i.tick(4);
        status(8'h05, 8'h04);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_latch();
        t_write_read();
        t_guard();
        t_bad_op();
        t_mode3();
        stop_test();
    end
    initial
    begin
        #1000000;
        fail_count++;
        stop_test();
    end
endmodule // test_spi_eeprom_slave_front_end
bind se_spi_eeprom se_checker #(.TWR_CYC(TWR_CYC)) se_checker_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .active_o(active_o), .standby_o(standby_o), .busy_o(busy_o)
);
`default_nettype wire
